// ### dv/psc_checker_props.sv
`timescale 1ns/1ns
module psc_checker (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire [7:0] paddr,
   input wire pready,
   input wire pslverr,
   input wire shift_clock,
   input wire shift_data,
   input wire [5:0] select_out,
   input wire irq,
   input wire dma_req
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   pready_pulse_a: assert property (pready |=> !pready)
      else $error("pready held past one cycle");
   wait_state_a: assert property ($rose(penable) && psel |-> !pready ##1 pready)
      else $error("access answer not after one wait state");
   err_decode_a: assert property (pready |-> pslverr == (paddr > 8'h2c || paddr[1:0] != 2'h0))
      else $error("error response does not match address map");
   idle_select_a: assert property (!select_out[4] && !select_out[5] |-> select_out == 6'h00)
      else $error("select line active outside a frame");
   idle_clock_a: assert property (select_out == 6'h00 |-> !shift_clock)
      else $error("shift clock high between frames");
   data_stable_a: assert property (shift_clock |-> $stable(shift_data))
      else $error("shift data moved while clock high");
   kind_excl_a: assert property (!(select_out[4] && select_out[5]))
      else $error("two frame kinds at once");
   start_low_a: assert property ($rose(select_out[4] | select_out[5]) |-> !shift_clock)
      else $error("frame opened with clock high");
   dma_pulse_a: assert property (dma_req |=> !dma_req)
      else $error("dma request longer than one cycle");
   cover property ($rose(select_out[2]));
   cover property ($rose(irq));
   cover property (dma_req);
   cover property (pslverr);
endmodule // psc_checker

bind power_switch_serial_channel psc_checker i_psc_checker (.pclk, .presetn, .psel, .penable,
   .paddr, .pready, .pslverr, .shift_clock, .shift_data, .select_out, .irq, .dma_req);

// ### dv/switch_model.sv
`timescale 1ns/1ns
module switch_model #(parameter int BIT = 16) (
   input wire pclk,
   input wire presetn,
   input wire shift_clock,
   input wire shift_data,
   input wire [5:0] select_out,
   output logic [7:0] lines
);
   logic sc_q;
   logic [5:0] sel_q;
   logic [32:0] word;
   int nbits;
   initial lines = 8'hff;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sc_q <= 1'b0;
         sel_q <= 6'h00;
         nbits <= 0;
         word <= 33'h0;
      end else begin
         sc_q <= shift_clock;
         sel_q <= select_out;
         if (sel_q == 6'h00 && select_out != 6'h00) begin
            nbits <= 0;
         end else if (shift_clock && !sc_q) begin
            word <= {shift_data, word[32:1]};
            nbits <= nbits + 1;
         end
      end
   end
   // a one-cycle dip first, which the receiver must not take as a start bit
   task automatic send(input [2:0] n, input [15:0] d, input int len, input logic bad);
      int i;
      logic b;
      lines[n] <= 1'b0;
      @(posedge pclk);
      lines[n] <= 1'b1;
      repeat (2 * BIT) @(posedge pclk);
      for (i = 0; i < len + 3; i++) begin
         b = (i == 0) ? 1'b0 : (i <= len) ? d[i-1] : (i == len + 1) ? (^d) ^ bad : 1'b1;
         lines[n] <= b;
         repeat (BIT) @(posedge pclk);
      end
      lines[n] <= 1'b1;
   endtask
endmodule // switch_model

// ### dv/tb_power_switch_serial_channel.sv
`timescale 1ns/1ns
`include "power_switch_serial_channel_consts.vh"
`define chk(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; \
   $display("unexpected at %0t: %h vs %h", $time, (a), (b)); end end
module tb_power_switch_serial_channel;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic timer_trigger = 0, emergency_stop = 0, e;
   logic [7:0] paddr = 8'h00, lines;
   logic [31:0] pwdata = 32'h0, prdata, r, d, s, mk, v, x;
   logic pready, pslverr, shift_clock, shift_data, irq, dma_req;
   logic [15:0] alo = 16'h0, ahi = 16'h0;
   logic [5:0] select_out;
   int n_errors = 0, num_checks = 0, seed = 55292, cycles = 0, m, n, n_dma = 0;
   initial forever #10 pclk = ~pclk;
   power_switch_serial_channel i_power_switch_serial_channel (.pclk, .presetn, .psel,
      .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
      .alternate_data_low(alo), .alternate_data_high(ahi), .timer_trigger, .emergency_stop,
      .upstream_serial_inputs(lines), .shift_clock, .shift_data, .select_out, .irq, .dma_req);
   switch_model i_switch_model (.pclk, .presetn, .shift_clock, .shift_data, .select_out,
      .lines);
   task stop_test;
      if (n_errors == 0 && num_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task apb(input logic w, input [7:0] a, input [31:0] wd);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // poll status; only some callers check the bit it waited for
   task wait_ev(input int b);
      int k;
      for (k = 0; k < 200; k++) begin
         apb(1'b0, `REG_STATUS, 32'h0);
         if (r[b] === 1'b1) break;
      end
   endtask
   function automatic [31:0] fexp(input [31:0] d, s, a, mk, v, input logic em);
      fexp = (d & ~s) | (a & s);
      if (em) fexp = (fexp & ~mk) | (v & mk);
   endfunction
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (dma_req === 1'b1)
         n_dma <= n_dma + 1;
      if (cycles == 30000) begin
         n_errors++;
         stop_test;
      end
   end
   initial begin
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      apb(1'b0, `REG_CTRL, 32'h0);
      `chk(r, `CTRL_RESET)
      apb(1'b0, `REG_FDIV, 32'h0);
      `chk(r[9:0], `FDIV_RESET)
      apb(1'b0, 8'h40, 32'h0);
      `chk({e, r}, 33'h1_0000_0000)
      apb(1'b1, 8'h30, 32'hffff_ffff);
      `chk(e, 1'b1)
      for (m = 0; m < 2; m++) begin
         d = $random(seed);
         s = $random(seed);
         mk = $random(seed);
         v = $random(seed);
         x = $random(seed);
         alo <= x[15:0];
         ahi <= x[31:16];
         emergency_stop <= m[0];
         apb(1'b1, `REG_DATA, d);
         apb(1'b1, `REG_SRCSEL, s);
         apb(1'b1, `REG_EMG_MASK, mk);
         apb(1'b1, `REG_EMG_VALUE, v);
         apb(1'b1, `REG_IEN, {31'h0, ~m[0]});
         apb(1'b1, `REG_CTRL, 32'h19 | (m << `CTRL_TRIG_LO));
         if (m) begin
            timer_trigger <= 1'b1;
            repeat (4) @(posedge pclk);
            timer_trigger <= 1'b0;
         end else apb(1'b1, `REG_TRIG, 32'h1);
         wait_ev(`EV_TX_DONE);
         `chk(r[`EV_TX_DONE], 1'b1)
         `chk(i_switch_model.word, {fexp(d, s, x, mk, v, m[0]), 1'b1})
         `chk(i_switch_model.nbits, 33)
         `chk(irq, ~m[0])
         apb(1'b1, `REG_CLEAR, 32'h7);
         @(posedge pclk);
         `chk(irq, 1'b0)
      end
      emergency_stop <= 1'b0;
      // free running: frames follow each other until transmit is disabled
      apb(1'b1, `REG_CTRL, 32'h1d);
      wait_ev(`EV_TX_DONE);
      apb(1'b1, `REG_CTRL, 32'h0);
      repeat (200) @(posedge pclk);
      `chk(i_switch_model.word, {fexp(d, s, x, mk, v, 1'b0), 1'b1})
      `chk(i_switch_model.nbits, 33)
      apb(1'b1, `REG_CLEAR, 32'h7);
      // data disabled: a passive frame of zeros
      apb(1'b1, `REG_CTRL, 32'h11);
      apb(1'b1, `REG_TRIG, 32'h1);
      wait_ev(`EV_TX_DONE);
      `chk(r[`EV_TX_DONE], 1'b1)
      `chk(i_switch_model.word, 33'h0)
      `chk(i_switch_model.nbits, 33)
      apb(1'b1, `REG_CLEAR, 32'h7);
      for (m = 0; m < 2; m++) begin
         d = $random(seed);
         apb(1'b1, `REG_CTRL, 32'h09 | (m << `CTRL_SEL_EN));
         apb(1'b1, `REG_CMD, d);
         wait_ev(`EV_TX_DONE);
         `chk(i_switch_model.word[32:17], d[15:0])
         `chk(i_switch_model.nbits, 16 + m)
         apb(1'b1, `REG_CLEAR, 32'h7);
      end
      // upstream: a 16-bit frame, a 12-bit frame, then one with flipped parity
      for (m = 0; m < 3; m++) begin
         n = $random(seed) & 7;
         d = $random(seed) & ((m == 1) ? 32'hfff : 32'hffff);
         apb(1'b1, `REG_CTRL, 32'h2020 | (n << `CTRL_RXSEL_LO) | ((m == 1) << `CTRL_RX12));
         i_switch_model.send(n[2:0], d[15:0], (m == 1) ? 12 : 16, m == 2);
         wait_ev(`EV_RX_DONE);
         `chk(r[`EV_PARITY], m == 2)
         apb(1'b0, `REG_RXDATA, 32'h0);
         if (m < 2) `chk(r[15:0], d[15:0])
         `chk(n_dma, m + 1)
         apb(1'b1, `REG_CLEAR, 32'h7);
      end
      stop_test;
   end
endmodule // tb_power_switch_serial_channel

// ### src/power_switch_serial_channel.v
`timescale 1ns/1ns
`include "power_switch_serial_channel_consts.vh"
module power_switch_serial_channel (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire [15:0] alternate_data_low,
   input wire [15:0] alternate_data_high,
   input wire timer_trigger,
   input wire emergency_stop,
   input wire [7:0] upstream_serial_inputs,
   output reg shift_clock,
   output reg shift_data,
   output reg [5:0] select_out,
   output reg irq,
   output reg dma_req
);
   localparam S_IDLE = 1'b0;
   localparam S_SEND = 1'b1;
   localparam R_IDLE = 2'h0;
   localparam R_START = 2'h1;
   localparam R_BITS = 2'h2;
   // receive divisor 8 << sel, sel 0..6
   function [9:0] rx_divisor;
      input [2:0] sel;
      begin
         if (sel > 3'h6)
            rx_divisor = 10'h200;
         else
            rx_divisor = 10'h008 << sel;
      end
   endfunction
   reg [31:0] ctrl;
   reg [31:0] data_word;
   reg [31:0] srcsel;
   reg [15:0] cmd_word;
   reg [31:0] emg_mask;
   reg [31:0] emg_value;
   reg [`FDIV_WIDTH-1:0] fdiv;
   reg [15:0] rx_data;
   reg [`EV_COUNT-1:0] status;
   reg [`EV_COUNT-1:0] ien;
   reg cmd_pend;
   reg sw_pend;
   reg emg_s1, emg_s2, tmr_s1, tmr_s2, tmr_d;
   reg tx_state;
   reg tick;

   // apb: one wait state, then pready for one cycle
   wire apb_done = psel & penable & pready;
   wire wr = apb_done & pwrite;
   reg [31:0] rd_val;
   reg rd_ok;
   always @* begin
      rd_val = 32'h0000_0000;
      rd_ok = 1'b1;
      if (paddr == `REG_CTRL)
         rd_val = ctrl;
      else if (paddr == `REG_DATA)
         rd_val = data_word;
      else if (paddr == `REG_SRCSEL)
         rd_val = srcsel;
      else if (paddr == `REG_CMD)
         rd_val = {16'h0000, cmd_word};
      else if (paddr == `REG_TRIG || paddr == `REG_CLEAR)
         rd_val = 32'h0000_0000;
      else if (paddr == `REG_EMG_MASK)
         rd_val = emg_mask;
      else if (paddr == `REG_EMG_VALUE)
         rd_val = emg_value;
      else if (paddr == `REG_FDIV)
         rd_val = {22'h000000, fdiv};
      else if (paddr == `REG_RXDATA)
         rd_val = {16'h0000, rx_data};
      else if (paddr == `REG_STATUS)
         rd_val = {21'h000000, emg_s2, cmd_pend, tx_state, 5'h00, status};
      else if (paddr == `REG_IEN)
         rd_val = {29'h00000000, ien};
      else
         rd_ok = 1'b0;
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else begin
         pready <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~rd_ok;
         if (psel & penable & ~pready & ~pwrite)
            prdata <= rd_val;
      end
   end

   // synchronisers for pin-level inputs
   reg [7:0] sdi_s1, sdi_s2;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         emg_s1 <= 1'b0;
         emg_s2 <= 1'b0;
         tmr_s1 <= 1'b0;
         tmr_s2 <= 1'b0;
         tmr_d <= 1'b0;
         sdi_s1 <= 8'hff;
         sdi_s2 <= 8'hff;
      end else begin
         emg_s1 <= emergency_stop;
         emg_s2 <= emg_s1;
         tmr_s1 <= timer_trigger;
         tmr_s2 <= tmr_s1;
         if (tick) // edge held until a tick; a trigger shorter than a tick gap is lost unless it spans a tick
            tmr_d <= tmr_s2;
         sdi_s1 <= upstream_serial_inputs;
         sdi_s2 <= sdi_s1;
      end
   end

   // fractional divider: carry of the accumulator is the module clock tick
   reg [`FDIV_WIDTH-1:0] acc;
   wire [`FDIV_WIDTH:0] acc_sum = {1'b0, acc} + {1'b0, fdiv};
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc <= {`FDIV_WIDTH{1'b0}};
         tick <= 1'b0;
      end else begin
         acc <= acc_sum[`FDIV_WIDTH-1:0];
         tick <= acc_sum[`FDIV_WIDTH];
      end
   end
   // downstream source mixing and emergency override
   wire [31:0] alt_word = {alternate_data_high, alternate_data_low};
   wire [31:0] src_word = (data_word & ~srcsel) | (alt_word & srcsel);
   wire [31:0] emg_word = (src_word & ~emg_mask) | (emg_value & emg_mask);
   wire [31:0] tx_word = emg_s2 ? emg_word : src_word;
   wire [1:0] trig_mode = ctrl[`CTRL_TRIG_HI:`CTRL_TRIG_LO];
   wire sel_en = ctrl[`CTRL_SEL_EN];
   wire data_go = (trig_mode == `TRIG_SOFTWARE) ? sw_pend :
                  (trig_mode == `TRIG_TIMER) ? (tmr_s2 & ~tmr_d) :
                  (trig_mode == `TRIG_FREE);

   reg phase;
   reg [32:0] shreg;
   reg [5:0] bits_left;
   reg [5:0] bit_idx;
   reg [1:0] frame_kind;
   reg tx_done_pulse;
   wire tx_start = tx_state == S_IDLE && ctrl[`CTRL_TX_EN] && tick && (cmd_pend | data_go);
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_state <= S_IDLE;
         phase <= 1'b0;
         shreg <= 33'h0_0000_0000;
         bits_left <= 6'h00;
         bit_idx <= 6'h00;
         frame_kind <= 2'h0;
         tx_done_pulse <= 1'b0;
         shift_clock <= 1'b0;
         shift_data <= 1'b0;
         select_out <= 6'h00;
      end else begin
         tx_done_pulse <= 1'b0;
         case (tx_state)
            S_IDLE: begin
               shift_clock <= 1'b0;
               select_out <= 6'h00;
               if (tx_start) begin
                  // command beats data; data disabled gives a passive frame
                  if (cmd_pend) begin
                     frame_kind <= 2'h1;
                     shreg <= {16'h0000, cmd_word, 1'b0};
                     bits_left <= sel_en ? 6'd17 : 6'd16;
                  end else if (ctrl[`CTRL_DATA_EN]) begin
                     frame_kind <= 2'h0;
                     shreg <= {tx_word, 1'b1};
                     bits_left <= sel_en ? 6'd33 : 6'd32;
                  end else begin
                     frame_kind <= 2'h2;
                     shreg <= 33'h0_0000_0000;
                     bits_left <= sel_en ? 6'd33 : 6'd32;
                  end
                  bit_idx <= sel_en ? 6'd0 : 6'd1;
                  phase <= 1'b0;
                  tx_state <= S_SEND;
               end
            end
            S_SEND: begin
               if (tick) begin
                  phase <= ~phase;
                  shift_clock <= phase;
                  if (!phase && bits_left == 6'd0) begin
                     tx_state <= S_IDLE;
                     select_out <= 6'h00;
                     shift_data <= 1'b0;
                     tx_done_pulse <= 1'b1;
                  end else if (!phase) begin
                     shift_data <= shreg[bit_idx];
                     select_out[0] <= frame_kind == 2'h0 && bit_idx != 6'd0 && bit_idx < 6'd17;
                     select_out[1] <= frame_kind == 2'h0 && bit_idx >= 6'd17;
                     select_out[2] <= frame_kind == 2'h1;
                     select_out[3] <= bit_idx == 6'd0;
                     select_out[4] <= frame_kind != 2'h2;
                     select_out[5] <= frame_kind == 2'h2;
                     bit_idx <= bit_idx + 6'd1;
                     bits_left <= bits_left - 6'd1;
                  end
               end
            end
            default: tx_state <= S_IDLE;
         endcase
      end
   end

   // upstream: selector, spike filter, asynchronous receiver
   wire sdi_pick = sdi_s2[ctrl[`CTRL_RXSEL_HI:`CTRL_RXSEL_LO]];
   reg [`SPIKE_LEN-1:0] filt_hist;
   reg rx_line;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         filt_hist <= {`SPIKE_LEN{1'b1}};
         rx_line <= 1'b1;
      end else begin
         filt_hist <= {filt_hist[`SPIKE_LEN-2:0], sdi_pick};
         // level moves only after a full run of equal samples
         if (&filt_hist)
            rx_line <= 1'b1;
         else if (~|filt_hist)
            rx_line <= 1'b0;
      end
   end

   wire [9:0] rx_div = rx_divisor(ctrl[`CTRL_RXDIV_HI:`CTRL_RXDIV_LO]);
   wire [4:0] rx_len = ctrl[`CTRL_RX12] ? 5'd12 : 5'd16;
   reg [1:0] rx_state;
   reg [9:0] rx_cnt;
   reg [4:0] rx_bit;
   reg [15:0] rx_shift;
   reg rx_par;
   reg rx_done_pulse;
   reg par_err_pulse;
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_state <= R_IDLE;
         rx_cnt <= 10'h000;
         rx_bit <= 5'h00;
         rx_shift <= 16'h0000;
         rx_par <= 1'b0;
         rx_data <= 16'h0000;
         rx_done_pulse <= 1'b0;
         par_err_pulse <= 1'b0;
      end else begin
         rx_done_pulse <= 1'b0;
         par_err_pulse <= 1'b0;
         case (rx_state)
            R_IDLE: begin
               rx_cnt <= 10'h000;
               if (ctrl[`CTRL_RX_EN] && !rx_line)
                  rx_state <= R_START;
            end
            R_START: begin
               if (tick) begin
                  rx_cnt <= rx_cnt + 10'h001;
                  if (rx_cnt == (rx_div >> 1) - 10'h001) begin
                     rx_cnt <= 10'h000;
                     rx_bit <= 5'h00;
                     rx_par <= 1'b0;
                     rx_state <= rx_line ? R_IDLE : R_BITS;
                  end
               end
            end
            R_BITS: begin
               if (tick) begin
                  rx_cnt <= rx_cnt + 10'h001;
                  if (rx_cnt == rx_div - 10'h001) begin
                     rx_cnt <= 10'h000;
                     rx_bit <= rx_bit + 5'h01;
                     if (rx_bit < rx_len) begin
                        rx_shift[rx_bit[3:0]] <= rx_line;
                        rx_par <= rx_par ^ rx_line;
                     end else if (rx_bit == rx_len) begin
                        par_err_pulse <= rx_par ^ rx_line;
                     end else begin
                        rx_data <= ctrl[`CTRL_RX12] ? {4'h0, rx_shift[11:0]} : rx_shift;
                        rx_done_pulse <= 1'b1;
                        rx_state <= R_IDLE;
                     end
                  end
               end
            end
            default: rx_state <= R_IDLE;
         endcase
      end
   end

   // register writes, sticky events, request outputs
   wire [`EV_COUNT-1:0] events = {par_err_pulse, rx_done_pulse, tx_done_pulse};
   wire [`EV_COUNT-1:0] clr = (wr && paddr == `REG_CLEAR) ? pwdata[`EV_COUNT-1:0] :
                              {`EV_COUNT{1'b0}};
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= `CTRL_RESET;
         data_word <= 32'h0000_0000;
         srcsel <= 32'h0000_0000;
         cmd_word <= 16'h0000;
         emg_mask <= 32'h0000_0000;
         emg_value <= 32'h0000_0000;
         fdiv <= `FDIV_RESET;
         ien <= {`EV_COUNT{1'b0}};
         status <= {`EV_COUNT{1'b0}};
         cmd_pend <= 1'b0;
         sw_pend <= 1'b0;
         irq <= 1'b0;
         dma_req <= 1'b0;
      end else begin
         if (wr && paddr == `REG_CTRL)
            ctrl <= pwdata;
         if (wr && paddr == `REG_DATA)
            data_word <= pwdata;
         if (wr && paddr == `REG_SRCSEL)
            srcsel <= pwdata;
         if (wr && paddr == `REG_EMG_MASK)
            emg_mask <= pwdata;
         if (wr && paddr == `REG_EMG_VALUE)
            emg_value <= pwdata;
         if (wr && paddr == `REG_FDIV)
            fdiv <= pwdata[`FDIV_WIDTH-1:0];
         if (wr && paddr == `REG_IEN)
            ien <= pwdata[`EV_COUNT-1:0];
         if (wr && paddr == `REG_CMD) begin
            cmd_word <= pwdata[15:0];
            cmd_pend <= 1'b1;
         end else if (tx_start)
            cmd_pend <= 1'b0;
         if (wr && paddr == `REG_TRIG && pwdata[0])
            sw_pend <= 1'b1;
         else if (tx_start && !cmd_pend && trig_mode == `TRIG_SOFTWARE)
            sw_pend <= 1'b0;
         // a new event wins over a clear in the same cycle
         status <= (status & ~clr) | events;
         irq <= |(((status & ~clr) | events) & ien);
         dma_req <= rx_done_pulse & ctrl[`CTRL_DMA_EN];
      end
   end
endmodule // power_switch_serial_channel

// ### src/power_switch_serial_channel_consts.vh
`ifndef POWER_SWITCH_SERIAL_CHANNEL_CONSTS_VH
`define POWER_SWITCH_SERIAL_CHANNEL_CONSTS_VH
// register byte offsets
`define REG_CTRL 8'h00
`define REG_DATA 8'h04
`define REG_SRCSEL 8'h08
`define REG_CMD 8'h0c
`define REG_TRIG 8'h10
`define REG_EMG_MASK 8'h14
`define REG_EMG_VALUE 8'h18
`define REG_FDIV 8'h1c
`define REG_RXDATA 8'h20
`define REG_STATUS 8'h24
`define REG_CLEAR 8'h28
`define REG_IEN 8'h2c
// control register fields
`define CTRL_TX_EN 0
`define CTRL_TRIG_LO 1
`define CTRL_TRIG_HI 2
`define CTRL_DATA_EN 3
`define CTRL_SEL_EN 4
`define CTRL_RX_EN 5
`define CTRL_RXSEL_LO 6
`define CTRL_RXSEL_HI 8
`define CTRL_RXDIV_LO 9
`define CTRL_RXDIV_HI 11
`define CTRL_RX12 12
`define CTRL_DMA_EN 13
`define CTRL_RESET 32'h0000_0000
// trigger modes
`define TRIG_SOFTWARE 2'h0
`define TRIG_TIMER 2'h1
`define TRIG_FREE 2'h2
// status / event bits
`define EV_TX_DONE 0
`define EV_RX_DONE 1
`define EV_PARITY 2
`define EV_COUNT 3
`define ST_TX_BUSY 8
`define ST_CMD_PEND 9
`define ST_EMERGENCY 10
// fractional divider: step / 1024 of pclk
`define FDIV_WIDTH 10
`define FDIV_RESET 10'h200
// spike filter length in pclk samples
`define SPIKE_LEN 3
`endif
